//--- include/vvt_pkg.sv
// constants and carrier types for the vertical timing and overflow block
package vvt_pkg;

    // port selects of the indexed register pair
    localparam logic       PORT_INDEX          = 1'b0;
    localparam logic       PORT_DATA           = 1'b1;
    localparam int         IDX_W               = 7;

    // register indices behind the data port
    localparam logic [6:0] IDX_VTOTAL_LOW      = 7'h06;
    localparam logic [6:0] IDX_VOVERFLOW       = 7'h07;
    localparam logic [6:0] IDX_PRESET_ROW      = 7'h08;
    localparam logic [6:0] IDX_MAX_SCAN        = 7'h09;
    localparam logic [6:0] IDX_START_HIGH      = 7'h0c;
    localparam logic [6:0] IDX_START_LOW       = 7'h0d;
    localparam logic [6:0] IDX_VSYNC_LOW       = 7'h10;
    localparam logic [6:0] IDX_VDE_END_LOW     = 7'h12;
    localparam logic [6:0] IDX_VBLANK_LOW      = 7'h15;
    localparam logic [6:0] IDX_LCMP_LOW        = 7'h18;

    // overflow register bit positions
    localparam int         OVF_VT8             = 0;
    localparam int         OVF_VDE8            = 1;
    localparam int         OVF_VSS8            = 2;
    localparam int         OVF_VBS8            = 3;
    localparam int         OVF_LC8             = 4;
    localparam int         OVF_VT9             = 5;
    localparam int         OVF_VDE9            = 6;
    localparam int         OVF_VSS9            = 7;
    // writable bits of the overflow register under group-0 protection
    localparam logic [7:0] OVF_PROT_KEEP       = 8'h10;

    // maximum scan line register bit positions
    localparam int         MSL_VBS9            = 5;
    localparam int         MSL_LC9             = 6;
    localparam int         MSL_DSCAN           = 7;

    // preset row scan register fields
    localparam logic [7:0] PRS_RD_MASK         = 8'h7f;

    // reset values
    localparam logic [7:0] RST_BYTE            = 8'h00;
    localparam logic [7:0] RST_MAX_SCAN        = 8'h00;
    localparam logic [6:0] RST_INDEX           = 7'h00;

    // panning byte widths in pixels
    localparam logic [5:0] PAN_STEP_NINE       = 6'h09;
    localparam logic [5:0] PAN_STEP_EIGHT      = 6'h08;

    // vertical sync length in scan lines
    localparam logic [9:0] VSYNC_LINES         = 10'h002;

    typedef struct packed {
        logic [9:0] total;
        logic [9:0] de_end;
        logic [9:0] sync_start;
        logic [9:0] blank_start;
        logic [9:0] line_cmp;
    } vvt_timing_s;

    typedef enum logic [1:0] {
        VVT_SYNC_OFF = 2'b01,
        VVT_SYNC_ON  = 2'b10
    } vvt_sync_e;

endpackage : vvt_pkg

//--- design/vvt_vertical_timing.sv
// vertical timing with overflow assembly, line compare split, panning and row scan preset
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1: vertical total is low byte plus overflow bit 0 as bit 8, bit 5 as bit 9.
// RL2: software sets vertical total to total frame scan lines minus two.
// RL3: display end is low byte plus overflow bit 1 as bit 8, bit 6 as bit 9.
// RL4: software sets display end to last active line number, active count minus one.
// RL5: sync start is low byte plus overflow bit 2 as bit 8, bit 7 as bit 9.
// RL6: blank start is low byte, overflow bit 3 as bit 8, max-scan bit 5 as bit 9.
// RL7: line compare is low byte, overflow bit 4 as bit 8, max-scan bit 6 as bit 9.
// RL8: on the compare line the memory address counter restarts at zero.
// RL9: lines above compare fetch from start address, from compare line onward from zero.
// RL10: line zero is the first active line; blank and sync start are line numbers.
// RL11: under group-0 protection overflow bits 7:5 and 3:0 ignore writes, bit 4 writable.
// RL12: byte panning in preset row bits 6:5 shifts image left zero to three bytes.
// RL13: panning codes give 0/9/18/27 pixels for nine-pixel text, else 0/8/16/24.
// RL14: nine-dot disable forces the eight-pixel panning amounts.
// RL15: byte panning adds to the pixel panning bits 3:0 for finer scrolling.
// RL16: starting row scan count picks the top text row's first character line.
// RL17: software normally leaves starting row scan count at zero.
// RL18: preset row register bit 7 reads as zero.
// RL19: double scanning advances the row scan counter every second scan line.
// RL20: software sets max-scan bits 4:0 to scan lines per text row minus one.
// RL21: line counter advances each scan line and wraps after total-implied count.
// RL22: display enable while line at or below end; sync and blank start on equality.
// RL23: row scan counter reloads from starting row scan count at each frame start.
module vvt_vertical_timing
    import vvt_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // indexed register port
    input  wire logic        i_port_sel,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    // mode and neighbour inputs
    input  wire logic        i_grp0_protect,
    input  wire logic        i_nine_pixel_text,
    input  wire logic        i_nine_dot_disable,
    input  wire logic [3:0]  i_pixel_panning,
    input  wire logic [7:0]  i_row_pitch,
    input  wire logic        i_line_start,
    // timing outputs
    output logic      [9:0]  o_line_cnt,
    output logic      [4:0]  o_row_scan,
    output logic      [15:0] o_mem_addr,
    output logic             o_vde,
    output logic             o_vblank,
    output logic             o_vsync,
    output logic             o_frame_start,
    output logic      [5:0]  o_pan_shift
);

    logic [6:0]  index_r;
    logic [7:0]  vtotal_low_r;
    logic [7:0]  overflow_r;
    logic [7:0]  preset_row_r;
    logic [7:0]  max_scan_r;
    logic [7:0]  start_high_r;
    logic [7:0]  start_low_r;
    logic [7:0]  vsync_low_r;
    logic [7:0]  vde_end_low_r;
    logic [7:0]  vblank_low_r;
    logic [7:0]  lcmp_low_r;

    logic [9:0]  line_r;
    logic [9:0]  line_nxt;
    logic [4:0]  row_r;
    logic [4:0]  row_nxt;
    logic        dscan_phase_r;
    logic [15:0] row_base_r;
    logic [15:0] addr_r;
    logic        vde_r;
    logic        vblank_r;
    logic        frame_r;
    logic [5:0]  pan_r;
    logic [7:0]  rdata_r;
    logic [9:0]  sync_cnt_r;
    vvt_sync_e   sync_r;
    vvt_sync_e   sync_nxt;

    vvt_timing_s tim;
    logic        wr_data;
    logic        row_end;
    logic        frame_wrap;
    logic        row_adv;
    logic [5:0]  pan_step;
    logic [5:0]  pan_bytes;

    assign wr_data = i_wr && (i_port_sel == PORT_DATA);

    // assembly of the ten-bit vertical values
    always_comb begin
        tim             = '0;
        tim.total       = {overflow_r[OVF_VT9], overflow_r[OVF_VT8], vtotal_low_r};          // see RL1
        tim.de_end      = {overflow_r[OVF_VDE9], overflow_r[OVF_VDE8], vde_end_low_r};       // see RL3
        tim.sync_start  = {overflow_r[OVF_VSS9], overflow_r[OVF_VSS8], vsync_low_r};         // see RL5
        tim.blank_start = {max_scan_r[MSL_VBS9], overflow_r[OVF_VBS8], vblank_low_r};        // see RL6
        tim.line_cmp    = {max_scan_r[MSL_LC9], overflow_r[OVF_LC8], lcmp_low_r};            // see RL7
    end

    // index register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            index_r <= RST_INDEX;
        end else if (i_ce && i_wr && (i_port_sel == PORT_INDEX)) begin
            index_r <= i_wdata[IDX_W-1:0];
        end
    end

    // data registers behind the index
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vtotal_low_r  <= RST_BYTE;
            overflow_r    <= RST_BYTE;
            preset_row_r  <= RST_BYTE;
            max_scan_r    <= RST_MAX_SCAN;
            start_high_r  <= RST_BYTE;
            start_low_r   <= RST_BYTE;
            vsync_low_r   <= RST_BYTE;
            vde_end_low_r <= RST_BYTE;
            vblank_low_r  <= RST_BYTE;
            lcmp_low_r    <= RST_BYTE;
        end else if (i_ce && wr_data) begin
            case (index_r)
                IDX_VTOTAL_LOW: begin
                    vtotal_low_r <= i_wdata;
                end
                IDX_VOVERFLOW: begin
                    if (i_grp0_protect) begin
                        overflow_r <= (overflow_r & ~OVF_PROT_KEEP) | (i_wdata & OVF_PROT_KEEP);  // see RL11
                    end else begin
                        overflow_r <= i_wdata;
                    end
                end
                IDX_PRESET_ROW: begin
                    preset_row_r <= i_wdata & PRS_RD_MASK;
                end
                IDX_MAX_SCAN: begin
                    max_scan_r <= i_wdata;
                end
                IDX_START_HIGH: begin
                    start_high_r <= i_wdata;
                end
                IDX_START_LOW: begin
                    start_low_r <= i_wdata;
                end
                IDX_VSYNC_LOW: begin
                    vsync_low_r <= i_wdata;
                end
                IDX_VDE_END_LOW: begin
                    vde_end_low_r <= i_wdata;
                end
                IDX_VBLANK_LOW: begin
                    vblank_low_r <= i_wdata;
                end
                IDX_LCMP_LOW: begin
                    lcmp_low_r <= i_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read data, registered
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= RST_BYTE;
        end else if (i_ce && i_rd) begin
            if (i_port_sel == PORT_INDEX) begin
                rdata_r <= {1'b0, index_r};
            end else begin
                case (index_r)
                    IDX_VTOTAL_LOW:  rdata_r <= vtotal_low_r;
                    IDX_VOVERFLOW:   rdata_r <= overflow_r;
                    IDX_PRESET_ROW:  rdata_r <= preset_row_r & PRS_RD_MASK;  // see RL18
                    IDX_MAX_SCAN:    rdata_r <= max_scan_r;
                    IDX_START_HIGH:  rdata_r <= start_high_r;
                    IDX_START_LOW:   rdata_r <= start_low_r;
                    IDX_VSYNC_LOW:   rdata_r <= vsync_low_r;
                    IDX_VDE_END_LOW: rdata_r <= vde_end_low_r;
                    IDX_VBLANK_LOW:  rdata_r <= vblank_low_r;
                    IDX_LCMP_LOW:    rdata_r <= lcmp_low_r;
                    default:         rdata_r <= RST_BYTE;
                endcase
            end
        end
    end

    // line counter: total value is lines minus two, so last line is total plus one
    always_comb begin
        frame_wrap = (line_r >= (tim.total + 10'h001));
        if (frame_wrap) begin
            line_nxt = '0;                                      // see RL21
        end else begin
            line_nxt = line_r + 10'h001;                        // see RL21
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_r <= '0;
        end else if (i_ce && i_line_start) begin
            line_r <= line_nxt;                                 // see RL10
        end
    end

    // row scan counter with double scanning and frame preset
    assign row_adv = !max_scan_r[MSL_DSCAN] || dscan_phase_r;  // see RL19
    assign row_end = (row_r >= max_scan_r[4:0]);

    always_comb begin
        if (line_nxt == '0) begin
            row_nxt = preset_row_r[4:0];                        // see RL16
        end else if (!row_adv) begin
            row_nxt = row_r;
        end else if (row_end) begin
            row_nxt = '0;
        end else begin
            row_nxt = row_r + 5'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            row_r         <= '0;
            dscan_phase_r <= 1'b0;
        end else if (i_ce && i_line_start) begin
            row_r <= row_nxt;                                   // see RL23
            if (line_nxt == '0) begin
                dscan_phase_r <= 1'b0;
            end else begin
                dscan_phase_r <= !dscan_phase_r;                // see RL19
            end
        end
    end

    // display memory address: start address at frame top, zero from the compare line
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            row_base_r <= '0;
            addr_r     <= '0;
        end else if (i_ce && i_line_start) begin
            if (line_nxt == '0) begin
                row_base_r <= {start_high_r, start_low_r};      // see RL9
                addr_r     <= {start_high_r, start_low_r};      // see RL9
            end else if (line_nxt == tim.line_cmp) begin
                row_base_r <= '0;                               // see RL8
                addr_r     <= '0;                               // see RL8
            end else if (row_adv && row_end) begin
                row_base_r <= row_base_r + {8'h00, i_row_pitch};
                addr_r     <= row_base_r + {8'h00, i_row_pitch};
            end else begin
                addr_r <= row_base_r;
            end
        end
    end

    // display enable, blanking and frame start
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vde_r    <= 1'b0;
            vblank_r <= 1'b0;
            frame_r  <= 1'b0;
        end else if (i_ce) begin
            frame_r <= i_line_start && (line_nxt == '0);
            if (i_line_start) begin
                vde_r <= (line_nxt <= tim.de_end);              // see RL22
                if (line_nxt == '0) begin
                    vblank_r <= 1'b0;
                end else if (line_nxt == tim.blank_start) begin
                    vblank_r <= 1'b1;                           // see RL22
                end
            end
        end
    end

    // vertical sync pulse state
    always_comb begin
        sync_nxt = sync_r;
        case (sync_r)
            VVT_SYNC_OFF: begin
                if (i_line_start && (line_nxt == tim.sync_start)) begin
                    sync_nxt = VVT_SYNC_ON;                     // see RL22
                end
            end
            VVT_SYNC_ON: begin
                if (i_line_start && (sync_cnt_r >= VSYNC_LINES - 10'h001)) begin
                    sync_nxt = VVT_SYNC_OFF;
                end
            end
            default: begin
                sync_nxt = VVT_SYNC_OFF;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_r     <= VVT_SYNC_OFF;
            sync_cnt_r <= '0;
        end else if (i_ce) begin
            sync_r <= sync_nxt;
            if (sync_nxt != VVT_SYNC_ON) begin
                sync_cnt_r <= '0;
            end else if (sync_r == VVT_SYNC_ON && i_line_start) begin
                sync_cnt_r <= sync_cnt_r + 10'h001;
            end
        end
    end

    // horizontal panning amount
    always_comb begin
        if (i_nine_pixel_text && !i_nine_dot_disable) begin
            pan_step = PAN_STEP_NINE;                           // see RL13
        end else begin
            pan_step = PAN_STEP_EIGHT;                          // see RL14
        end
        case (preset_row_r[6:5])                                // see RL12
            2'b00:   pan_bytes = '0;
            2'b01:   pan_bytes = pan_step;
            2'b10:   pan_bytes = 6'(pan_step << 1);
            2'b11:   pan_bytes = 6'((pan_step << 1) + pan_step);
            default: pan_bytes = '0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pan_r <= '0;
        end else if (i_ce) begin
            pan_r <= pan_bytes + {2'b00, i_pixel_panning};      // see RL15
        end
    end

    assign o_rdata       = rdata_r;
    assign o_line_cnt    = line_r;
    assign o_row_scan    = row_r;
    assign o_mem_addr    = addr_r;
    assign o_vde         = vde_r;
    assign o_vblank      = vblank_r;
    assign o_vsync       = sync_r[1];
    assign o_frame_start = frame_r;
    assign o_pan_shift   = pan_r;

endmodule : vvt_vertical_timing

`default_nettype wire

//--- dv/vvt_vertical_timing_checker.sv
// port assertions for the vertical timing block
`timescale 1ns/1ps
`default_nettype none
module vvt_vertical_timing_checker
    import vvt_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_rd,
    input  wire logic        i_line_start,
    input  wire logic [7:0]  o_rdata,
    input  wire logic [9:0]  o_line_cnt,
    input  wire logic [4:0]  o_row_scan,
    input  wire logic [15:0] o_mem_addr,
    input  wire logic        o_vde,
    input  wire logic        o_vblank,
    input  wire logic        o_frame_start,
    input  wire logic [5:0]  o_pan_shift
);
    logic ls;
    assign ls = i_ce && i_line_start;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_line_step: assert property (ls |=> (o_line_cnt == $past(o_line_cnt) + 10'h001) || (o_line_cnt == 10'h000))
        else $error("line counter did not step or wrap");
    a_line_hold: assert property (!ls |=> $stable(o_line_cnt))
        else $error("line counter moved without a line start");
    a_wrap_frame: assert property ((ls && o_line_cnt != 10'h000) |=> o_frame_start == (o_line_cnt == 10'h000))
        else $error("frame start does not match wrap");
    a_frame_origin: assert property ((o_frame_start && $past(i_ce)) |-> $past(ls) && o_line_cnt == 10'h000)
        else $error("frame start away from line zero");
    a_frame_vde: assert property (o_frame_start |-> o_vde && !o_vblank)
        else $error("line zero not active");
    a_row_hold: assert property (!ls |=> $stable(o_row_scan))
        else $error("row scan moved without a line start");
    a_addr_hold: assert property (!ls |=> $stable(o_mem_addr))
        else $error("address moved without a line start");
    a_pan_range: assert property (o_pan_shift <= 6'h2a)
        else $error("pan shift out of range");
    a_ce_freeze: assert property (!i_ce |=> $stable(o_pan_shift) && $stable(o_vblank))
        else $error("state moved while clock enable low");
    a_rdata_hold: assert property (!(i_ce && i_rd) |=> $stable(o_rdata))
        else $error("read data changed without a read");
endmodule : vvt_vertical_timing_checker

bind vvt_vertical_timing vvt_vertical_timing_checker u_vvt_vertical_timing_checker (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_rd(i_rd), .i_line_start(i_line_start),
    .o_rdata(o_rdata), .o_line_cnt(o_line_cnt), .o_row_scan(o_row_scan), .o_mem_addr(o_mem_addr),
    .o_vde(o_vde), .o_vblank(o_vblank), .o_frame_start(o_frame_start), .o_pan_shift(o_pan_shift));
`default_nettype wire

//--- dv/vvt_monitor.sv
// display monitor model measuring frame, blank and sync timing
`timescale 1ns/1ps
`default_nettype none
module vvt_monitor (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic       i_line_start,
    input  wire logic       i_vde,
    input  wire logic       i_vblank,
    input  wire logic       i_vsync,
    input  wire logic       i_frame_start,
    input  wire logic [9:0] i_line_cnt,
    output logic      [9:0] o_lines,
    output logic      [9:0] o_vde_lines,
    output logic      [9:0] o_blank_line,
    output logic      [9:0] o_sync_line,
    output logic      [3:0] o_sync_len
);
    logic [9:0] lc_r, vc_r;
    logic [3:0] sl_r;
    logic       vb_q, vs_q, ls;
    assign ls = i_ce && i_line_start;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {lc_r, vc_r, sl_r, vb_q, vs_q} <= '0;
            {o_lines, o_vde_lines, o_blank_line, o_sync_line, o_sync_len} <= '0;
        end else begin
            vb_q <= i_vblank;
            vs_q <= i_vsync;
            lc_r <= i_frame_start ? 10'h000 : lc_r + 10'(ls);
            vc_r <= i_frame_start ? 10'h000 : vc_r + 10'(ls && i_vde);
            if (i_frame_start) begin
                o_lines     <= lc_r;
                o_vde_lines <= vc_r;
            end
            if (i_vblank && !vb_q) o_blank_line <= i_line_cnt;
            if (i_vsync && !vs_q) begin
                o_sync_line <= i_line_cnt;
                sl_r        <= 4'h0;
            end else begin
                sl_r <= sl_r + 4'(ls);
            end
            if (!i_vsync && vs_q) o_sync_len <= sl_r;
        end
    end
endmodule : vvt_monitor
`default_nettype wire

//--- dv/vvt_vertical_timing_tb_top.sv
// self-checking bench for the vertical timing block
`timescale 1ns/1ps
`default_nettype none
module vvt_vertical_timing_tb_top;
    import vvt_pkg::*;
    logic        i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_port_sel = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic        i_grp0_protect = 1'b0, i_nine_pixel_text = 1'b0, i_nine_dot_disable = 1'b0, i_line_start = 1'b0;
    logic [7:0]  i_wdata = 8'h00, i_row_pitch = 8'h00, o_rdata, r;
    logic [3:0]  i_pixel_panning = 4'h0, pp, m_slen;
    logic [9:0]  o_line_cnt, m_lines, m_vde, m_blank, m_sync;
    logic [4:0]  o_row_scan, pre;
    logic [15:0] o_mem_addr, st;
    logic        o_vde, o_vblank, o_vsync, o_frame_start;
    logic [5:0]  o_pan_shift;
    logic [1:0]  lcnt = 2'h0;
    int          n_mismatch = 0, n_tests = 0, cyc = 0;

    vvt_vertical_timing u_vvt_vertical_timing (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_port_sel(i_port_sel), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .i_grp0_protect(i_grp0_protect), .i_nine_pixel_text(i_nine_pixel_text),
        .i_nine_dot_disable(i_nine_dot_disable), .i_pixel_panning(i_pixel_panning), .i_row_pitch(i_row_pitch),
        .i_line_start(i_line_start), .o_line_cnt(o_line_cnt), .o_row_scan(o_row_scan), .o_mem_addr(o_mem_addr),
        .o_vde(o_vde), .o_vblank(o_vblank), .o_vsync(o_vsync), .o_frame_start(o_frame_start),
        .o_pan_shift(o_pan_shift));
    vvt_monitor u_vvt_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_line_start(i_line_start),
        .i_vde(o_vde), .i_vblank(o_vblank), .i_vsync(o_vsync), .i_frame_start(o_frame_start),
        .i_line_cnt(o_line_cnt), .o_lines(m_lines), .o_vde_lines(m_vde), .o_blank_line(m_blank),
        .o_sync_line(m_sync), .o_sync_len(m_slen));

    always #4 i_clk = ~i_clk;
    // one scan line every four clocks
    always @(negedge i_clk) begin
        lcnt <= lcnt + 2'h1;
        i_line_start <= (lcnt == 2'h3);
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic sel(input logic [6:0] idx);
        @(negedge i_clk);
        i_wr = 1'b1;
        i_port_sel = PORT_INDEX;
        i_wdata = {1'b0, idx};
    endtask : sel
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        sel(idx);
        @(negedge i_clk);
        i_port_sel = PORT_DATA;
        i_wdata = d;
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] idx, input logic [7:0] e);
        sel(idx);
        @(negedge i_clk);
        i_wr = 1'b0;
        i_rd = 1'b1;
        i_port_sel = PORT_DATA;
        @(negedge i_clk);
        i_rd = 1'b0;
        chk(16'(o_rdata), 16'(e));
    endtask : rd
    task automatic wait_fs();
        @(negedge i_clk);
        for (int k = 0; k < 5000 && o_frame_start !== 1'b1; k++) @(negedge i_clk);
        chk(16'(o_frame_start), 16'h0001);
    endtask : wait_fs
    task automatic wait_line(input logic [9:0] n);
        for (int k = 0; k < 5000 && o_line_cnt !== n; k++) @(negedge i_clk);
        chk(16'(o_line_cnt), 16'(n));
    endtask : wait_line
    function automatic logic [15:0] pan_exp(input logic [1:0] c, input logic nine, input logic dis, input logic [3:0] p);
        return 16'(c) * ((nine && !dis) ? 16'h0009 : 16'h0008) + 16'(p);
    endfunction : pan_exp

    initial begin
        r = 8'($urandom(32'hf3973ee9));
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
        rd(IDX_VOVERFLOW, 8'h00);
        rd(IDX_MAX_SCAN, 8'h00);
        rd(7'h3f, 8'h00);
        i_ce = 1'b0;
        repeat (5) @(negedge i_clk);
        i_ce = 1'b1;
        r = 8'($urandom_range(7, 0));
        st = 16'($urandom);
        pre = 5'($urandom_range(3, 0));
        i_row_pitch = 8'($urandom);
        wr(IDX_VTOTAL_LOW, 8'h08 + r);
        wr(IDX_VDE_END_LOW, r);
        wr(IDX_VSYNC_LOW, 8'h04 + r);
        wr(IDX_VBLANK_LOW, 8'h02 + r);
        wr(IDX_LCMP_LOW, 8'h40 + r);
        wr(IDX_START_HIGH, st[15:8]);
        wr(IDX_START_LOW, st[7:0]);
        wr(IDX_PRESET_ROW, {3'h0, pre});
        wr(IDX_MAX_SCAN, 8'h07);
        wr(IDX_VOVERFLOW, 8'h0f);
        wait_fs();
        wait_fs();
        chk(o_mem_addr, st);
        chk(16'(o_row_scan), 16'(pre));
        wait_line(10'h040 + 10'(r));
        chk(o_mem_addr, 16'h0000);
        wait_fs();
        @(negedge i_clk);
        chk(16'(m_lines), 16'h010a + 16'(r));
        chk(16'(m_vde), 16'h0101 + 16'(r));
        chk(16'(m_blank), 16'h0102 + 16'(r));
        chk(16'(m_sync), 16'h0104 + 16'(r));
        chk(16'(m_slen), 16'h0002);
        i_grp0_protect = 1'b1;
        wr(IDX_VOVERFLOW, 8'hf0);
        rd(IDX_VOVERFLOW, 8'h1f);
        wr(IDX_VOVERFLOW, 8'h0f);
        rd(IDX_VOVERFLOW, 8'h0f);
        i_grp0_protect = 1'b0;
        wr(IDX_PRESET_ROW, 8'hff);
        rd(IDX_PRESET_ROW, 8'h7f);
        wr(IDX_PRESET_ROW, 8'h00);
        wr(IDX_MAX_SCAN, 8'h83);
        wait_fs();
        wait_line(10'h001);
        chk(16'(o_row_scan), 16'h0000);
        wait_line(10'h002);
        chk(16'(o_row_scan), 16'h0001);
        for (int c = 0; c < 16; c++) begin
            pp = 4'($urandom);
            i_pixel_panning = pp;
            i_nine_pixel_text = c[2];
            i_nine_dot_disable = c[3];
            wr(IDX_PRESET_ROW, {1'b0, 2'(c), 5'h00});
            @(negedge i_clk);
            chk(16'(o_pan_shift), pan_exp(2'(c), c[2], c[3], pp));
        end
        wr(IDX_MAX_SCAN, 8'h27);
        wr(IDX_VOVERFLOW, 8'hf0);
        wait_fs();
        wait_line(10'h140 + 10'(r));
        chk(o_mem_addr, 16'h0000);
        wait_fs();
        @(negedge i_clk);
        chk(16'(m_lines), 16'h020a + 16'(r));
        chk(16'(m_vde), 16'h0201 + 16'(r));
        chk(16'(m_blank), 16'h0202 + 16'(r));
        chk(16'(m_sync), 16'h0204 + 16'(r));
        summarize();
    end
endmodule : vvt_vertical_timing_tb_top
`default_nettype wire
